//--- fcd_pkg.sv
package fcd_pkg;

  // Datapath and structure sizes.
  localparam int DATA_W      = 80;
  localparam int NUM_REGS    = 8;
  localparam int QUEUE_DEPTH = 4;

  // First opcode bytes.
  localparam logic [7:0] OPC_D8 = 8'hD8;
  localparam logic [7:0] OPC_D9 = 8'hD9;
  localparam logic [7:0] OPC_DA = 8'hDA;
  localparam logic [7:0] OPC_DB = 8'hDB;
  localparam logic [7:0] OPC_DC = 8'hDC;
  localparam logic [7:0] OPC_DD = 8'hDD;
  localparam logic [7:0] OPC_DE = 8'hDE;
  localparam logic [7:0] OPC_DF = 8'hDF;
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // Integer flag positions on the flag ports.
  localparam int FLG_CARRY  = 0;
  localparam int FLG_PARITY = 1;
  localparam int FLG_ZERO   = 2;

  // Clock counts, taken at the low end of each printed range.
  localparam logic [7:0] CYC_BAD      = 8'h01;
  localparam logic [7:0] CYC_MOVE     = 8'h04;
  localparam logic [7:0] CYC_CMP      = 8'h04;
  localparam logic [7:0] CYC_UCMP     = 8'h09;
  localparam logic [7:0] CYC_UCMP_MAX = 8'h0A;
  localparam logic [7:0] CYC_ICMP     = 8'h09;
  localparam logic [7:0] CYC_ICMP_MAX = 8'h0A;
  localparam logic [7:0] CYC_COS      = 8'h5C;
  localparam logic [7:0] CYC_COS_MAX  = 8'h8D;
  localparam logic [7:0] CYC_DECSTP   = 8'h04;
  localparam logic [7:0] CYC_INCSTP   = 8'h02;
  localparam logic [7:0] CYC_DIV      = 8'h18;
  localparam logic [7:0] CYC_DIV_MAX  = 8'h22;
  localparam logic [7:0] CYC_IDIV     = 8'h22;
  localparam logic [7:0] CYC_IDIV_MAX = 8'h26;
  localparam logic [7:0] CYC_FREE     = 8'h04;

  // Reset values and arithmetic requests.
  localparam logic [7:0]  TAG_RESET    = 8'hFF;
  localparam logic [1:0]  AOP_NONE     = 2'h0;
  localparam logic [1:0]  AOP_DIV      = 2'h1;
  localparam logic [1:0]  AOP_COS      = 2'h2;
  localparam logic [14:0] EXP_ALL_ONES = 15'h7FFF;

  typedef enum logic [3:0] {K_BAD, K_MOVE, K_CMPCC, K_CMPFL, K_COS, K_DEC, K_INC, K_DIV, K_FREE} fcd_kind_e;
  typedef enum logic [2:0] {MC_NONE, MC_PF_SET, MC_CF_CLR, MC_ZF_CLR, MC_CZ_CLR, MC_PF_CLR} fcd_mcond_e;
  typedef enum logic [1:0] {CMP_GT, CMP_LT, CMP_EQ, CMP_UN} fcd_cmp_e;
  typedef enum logic {ST_IDLE, ST_EXEC} fcd_state_e;

  typedef struct packed {
    fcd_kind_e  kind;
    fcd_mcond_e cond;
    logic [2:0] n;
    logic [1:0] pops;
    logic       to_n;
    logic       swap;
    logic       use_mem;
    logic [7:0] cyc;
  } fcd_dec_s;

  // Map a logical entry number onto a physical register.
  function automatic logic [2:0] fcd_phys(input logic [2:0] top, input logic [2:0] n);
    fcd_phys = 3'(top + n);
  endfunction

  // Compare two extended reals; NaNs give unordered, both zeros are equal.
  function automatic fcd_cmp_e fcd_compare(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic a_nan;
    logic b_nan;
    logic mag_lt;
    a_nan  = (a[78:64] == EXP_ALL_ONES) && (a[62:0] != '0);
    b_nan  = (b[78:64] == EXP_ALL_ONES) && (b[62:0] != '0);
    mag_lt = a[78:0] < b[78:0];
    if (a_nan || b_nan)
      fcd_compare = CMP_UN;
    else if ((a[78:0] == '0 && b[78:0] == '0) || a == b)
      fcd_compare = CMP_EQ;
    else if (a[79] != b[79])
      fcd_compare = a[79] ? CMP_LT : CMP_GT;
    else
      fcd_compare = (mag_lt ^ a[79]) ? CMP_LT : CMP_GT;
  endfunction

endpackage

//--- fcd_exec_unit.sv
// How it works
// - DA move to top if parity set.
// - DB move to top if carry clear.
// - DB move to top if zero clear.
// - DB move if carry and zero clear.
// - DB move if parity clear.
// - Compare top with entry or real, set code.
// - Compare into condition code, then pop once.
// - DE D9 compares with entry one, pops twice.
// - Ordered compare into integer flags, optional pop.
// - Unordered compare into flags, nine clocks, optional pop.
// - Integer operand compare, nine clocks, optional pop.
// - D9 FF replaces top with its cosine.
// - D9 F6 decrements top pointer, four clocks.
// - D9 F7 increments top pointer, two clocks.
// - DE divide into entry n, then pop.
// - Reversed divide forms, operand as dividend.
// - DE reversed divide into entry n, pop.
// - Integer operand divide, thirty-four clocks.
// - DD frees tag of entry n.
// - Entries resolve relative to the top pointer.
// - Queue four instructions while one executes.
module fcd_exec_unit
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  // Instruction handover
  input  wire logic                        instr_valid_i,
  input  wire logic [7:0]                  instr_opcode_i,
  input  wire logic [7:0]                  instr_modrm_i,
  input  wire logic [fcd_pkg::DATA_W-1:0]  instr_operand_i,
  output logic                             instr_ready_o,
  // Integer flags
  input  wire logic [2:0]                  int_flags_i,
  output logic [2:0]                       int_flags_o,
  output logic                             int_flags_we_o,
  // External arithmetic datapath
  output logic [1:0]                       arith_op_o,
  output logic [fcd_pkg::DATA_W-1:0]       arith_a_o,
  output logic [fcd_pkg::DATA_W-1:0]       arith_b_o,
  input  wire logic [fcd_pkg::DATA_W-1:0]  arith_result_i,
  // Register preload
  input  wire logic                        reg_load_i,
  input  wire logic [2:0]                  reg_load_index_i,
  input  wire logic [fcd_pkg::DATA_W-1:0]  reg_load_data_i,
  // Status
  output logic [3:0]                       cond_code_o,
  output logic [2:0]                       top_pointer_o,
  output logic [fcd_pkg::NUM_REGS-1:0]     tag_empty_o,
  output logic [fcd_pkg::DATA_W-1:0]       stack_top_o,
  output logic                             busy_o,
  output logic                             done_o,
  output logic                             bad_opcode_o
);
  import fcd_pkg::*;

  logic [7:0]        q_opc   [QUEUE_DEPTH];
  logic [7:0]        q_modrm [QUEUE_DEPTH];
  logic [DATA_W-1:0] q_opnd  [QUEUE_DEPTH];
  logic [1:0]        q_wr;
  logic [1:0]        q_rd;
  logic [2:0]        q_count;
  logic [2:0]        next_q_count;
  logic              push;
  logic              start;
  logic              commit;
  logic              load_ok;
  logic              move_ok;
  fcd_state_e        state;
  logic [7:0]        cnt;
  fcd_dec_s          d_start;
  fcd_dec_s          ex;
  logic [2:0]        s_src_phys;
  logic [DATA_W-1:0] s_src;
  logic [2:0]        ex_src;
  logic [2:0]        ex_dst;
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [2:0]        top;
  logic [2:0]        cmp_flags;
  logic [DATA_W-1:0] ex_a;
  logic [DATA_W-1:0] ex_b;

  function automatic fcd_dec_s fcd_mk(input fcd_kind_e k, input logic [7:0] c, input logic [2:0] n,
                                      input logic [1:0] p, input logic t, input logic s, input fcd_mcond_e mc);
    fcd_mk = '0;
    fcd_mk.kind = k;
    fcd_mk.cyc = c;
    fcd_mk.n = n;
    fcd_mk.pops = p;
    fcd_mk.to_n = t;
    fcd_mk.swap = s;
    fcd_mk.cond = mc;
  endfunction

  function automatic fcd_dec_s fcd_decode(input logic [7:0] opc, input logic [7:0] modrm);
    fcd_dec_s   d;
    logic [2:0] n;
    n = modrm[2:0];
    d = fcd_mk(K_BAD, CYC_BAD, n, 2'h0, 1'b0, 1'b0, MC_NONE);
    if (modrm[7:6] == MOD_REGISTER)
    begin
      casez ({opc, modrm})
        {OPC_DA, 8'b1101_1???}: d = fcd_mk(K_MOVE, CYC_MOVE, n, 2'h0, 1'b0, 1'b0, MC_PF_SET);
        {OPC_DB, 8'b1100_0???}: d = fcd_mk(K_MOVE, CYC_MOVE, n, 2'h0, 1'b0, 1'b0, MC_CF_CLR);
        {OPC_DB, 8'b1100_1???}: d = fcd_mk(K_MOVE, CYC_MOVE, n, 2'h0, 1'b0, 1'b0, MC_ZF_CLR);
        {OPC_DB, 8'b1101_0???}: d = fcd_mk(K_MOVE, CYC_MOVE, n, 2'h0, 1'b0, 1'b0, MC_CZ_CLR);
        {OPC_DB, 8'b1101_1???}: d = fcd_mk(K_MOVE, CYC_MOVE, n, 2'h0, 1'b0, 1'b0, MC_PF_CLR);
        {OPC_D8, 8'b1101_0???}: d = fcd_mk(K_CMPCC, CYC_CMP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_D8, 8'b1101_1???}: d = fcd_mk(K_CMPCC, CYC_CMP, n, 2'h1, 1'b0, 1'b0, MC_NONE);
        {OPC_DE, 8'hD9}:        d = fcd_mk(K_CMPCC, CYC_CMP, 3'h1, 2'h2, 1'b0, 1'b0, MC_NONE);
        {OPC_DB, 8'b1111_0???}: d = fcd_mk(K_CMPFL, CYC_CMP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DF, 8'b1111_0???}: d = fcd_mk(K_CMPFL, CYC_CMP, n, 2'h1, 1'b0, 1'b0, MC_NONE);
        {OPC_DB, 8'b1110_1???}: d = fcd_mk(K_CMPFL, CYC_UCMP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DF, 8'b1110_1???}: d = fcd_mk(K_CMPFL, CYC_UCMP, n, 2'h1, 1'b0, 1'b0, MC_NONE);
        {OPC_D9, 8'hFF}:        d = fcd_mk(K_COS, CYC_COS, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_D9, 8'hF6}:        d = fcd_mk(K_DEC, CYC_DECSTP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_D9, 8'hF7}:        d = fcd_mk(K_INC, CYC_INCSTP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DC, 8'b1111_1???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b1, 1'b1, MC_NONE);
        {OPC_D8, 8'b1111_0???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DE, 8'b1111_1???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h1, 1'b1, 1'b1, MC_NONE);
        {OPC_DC, 8'b1111_0???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b0, 1'b1, MC_NONE);
        {OPC_D8, 8'b1111_1???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b1, 1'b0, MC_NONE);
        {OPC_DE, 8'b1111_0???}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h1, 1'b1, 1'b0, MC_NONE);
        {OPC_DD, 8'b1100_0???}: d = fcd_mk(K_FREE, CYC_FREE, n, 2'h0, 1'b1, 1'b0, MC_NONE);
        default:                d = fcd_mk(K_BAD, CYC_BAD, n, 2'h0, 1'b0, 1'b0, MC_NONE);
      endcase
    end
    else
    begin
      case ({opc, modrm[5:3]})
        {OPC_D8, 3'h2}, {OPC_DC, 3'h2}: d = fcd_mk(K_CMPCC, CYC_CMP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_D8, 3'h3}, {OPC_DC, 3'h3}: d = fcd_mk(K_CMPCC, CYC_CMP, n, 2'h1, 1'b0, 1'b0, MC_NONE);
        {OPC_DA, 3'h2}, {OPC_DE, 3'h2}: d = fcd_mk(K_CMPCC, CYC_ICMP, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DA, 3'h3}, {OPC_DE, 3'h3}: d = fcd_mk(K_CMPCC, CYC_ICMP, n, 2'h1, 1'b0, 1'b0, MC_NONE);
        {OPC_D8, 3'h6}, {OPC_DC, 3'h6}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_D8, 3'h7}, {OPC_DC, 3'h7}: d = fcd_mk(K_DIV, CYC_DIV, n, 2'h0, 1'b0, 1'b1, MC_NONE);
        {OPC_DA, 3'h6}, {OPC_DE, 3'h6}: d = fcd_mk(K_DIV, CYC_IDIV, n, 2'h0, 1'b0, 1'b0, MC_NONE);
        {OPC_DA, 3'h7}, {OPC_DE, 3'h7}: d = fcd_mk(K_DIV, CYC_IDIV, n, 2'h0, 1'b0, 1'b1, MC_NONE);
        default:                        d = fcd_mk(K_BAD, CYC_BAD, n, 2'h0, 1'b0, 1'b0, MC_NONE);
      endcase
      d.use_mem = (d.kind != K_BAD);
    end
    fcd_decode = d;
  endfunction

  assign push    = instr_valid_i && instr_ready_o;
  assign start   = (state == ST_IDLE) && (q_count != 3'h0);
  assign commit  = (state == ST_EXEC) && (cnt == 8'h00);
  // Preloads only land on a quiet unit, so they never race an instruction.
  assign load_ok = reg_load_i && (state == ST_IDLE) && (q_count == 3'h0);
  assign d_start = fcd_decode(q_opc[q_rd], q_modrm[q_rd]);
  assign s_src_phys = fcd_phys(top, d_start.n);
  assign s_src      = d_start.use_mem ? q_opnd[q_rd] : regs[s_src_phys];
  assign cmp_flags  = fcd_flags(fcd_compare(arith_a_o, arith_b_o));
  assign next_q_count = 3'(q_count + {2'h0, push} - {2'h0, start});
  assign arith_a_o     = ex_a;
  assign arith_b_o     = ex_b;
  assign top_pointer_o = top;

  // Flags are {zero, parity, carry}; unordered sets all three.
  function automatic logic [2:0] fcd_flags(input fcd_cmp_e r);
    case (r)
      CMP_LT:  fcd_flags = 3'h1;
      CMP_EQ:  fcd_flags = 3'h4;
      CMP_UN:  fcd_flags = 3'h7;
      default: fcd_flags = 3'h0;
    endcase
  endfunction

  // Flags are read at commit so a late integer update is still seen.
  always_comb
  begin
    case (ex.cond)
      MC_PF_SET: move_ok = int_flags_i[FLG_PARITY];
      MC_CF_CLR: move_ok = !int_flags_i[FLG_CARRY];
      MC_ZF_CLR: move_ok = !int_flags_i[FLG_ZERO];
      MC_CZ_CLR: move_ok = !int_flags_i[FLG_CARRY] && !int_flags_i[FLG_ZERO];
      MC_PF_CLR: move_ok = !int_flags_i[FLG_PARITY];
      default:   move_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q_wr          <= 2'h0;
      q_rd          <= 2'h0;
      q_count       <= 3'h0;
      instr_ready_o <= 1'b0;
    end
    else
    begin
      q_wr          <= push ? 2'(q_wr + 2'h1) : q_wr;
      q_rd          <= start ? 2'(q_rd + 2'h1) : q_rd;
      q_count       <= next_q_count;
      instr_ready_o <= (next_q_count != 3'(QUEUE_DEPTH));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      q_opc[q_wr]   <= instr_opcode_i;
      q_modrm[q_wr] <= instr_modrm_i;
      q_opnd[q_wr]  <= instr_operand_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state      <= ST_IDLE;
      cnt        <= 8'h00;
      ex         <= '0;
      ex_a       <= '0;
      ex_b       <= '0;
      ex_src     <= 3'h0;
      ex_dst     <= 3'h0;
      arith_op_o <= AOP_NONE;
    end
    else if (start)
    begin
      state      <= ST_EXEC;
      cnt        <= 8'(d_start.cyc - 8'h01);
      ex         <= d_start;
      ex_a       <= d_start.swap ? s_src : regs[top];
      ex_b       <= d_start.swap ? regs[top] : s_src;
      ex_src     <= s_src_phys;
      ex_dst     <= d_start.to_n ? s_src_phys : top;
      arith_op_o <= (d_start.kind == K_DIV) ? AOP_DIV : ((d_start.kind == K_COS) ? AOP_COS : AOP_NONE);
    end
    else if (commit)
    begin
      state      <= ST_IDLE;
      arith_op_o <= AOP_NONE;
    end
    else if (state == ST_EXEC)
      cnt <= 8'(cnt - 8'h01);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= '0;
    end
    else if (load_ok)
      regs[reg_load_index_i] <= reg_load_data_i;
    else if (commit)
    begin
      case (ex.kind)
        K_MOVE:  if (move_ok) regs[top] <= arith_b_o;
        K_COS:   regs[top] <= arith_result_i;
        K_DIV:   regs[ex_dst] <= arith_result_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tag_empty_o <= TAG_RESET;
      top         <= 3'h0;
    end
    else if (load_ok)
      tag_empty_o[reg_load_index_i] <= 1'b0;
    else if (commit)
    begin
      case (ex.kind)
        K_MOVE:  if (move_ok) tag_empty_o[top] <= tag_empty_o[ex_src];
        K_COS:   tag_empty_o[top] <= 1'b0;
        K_DIV:   tag_empty_o[ex_dst] <= 1'b0;
        K_DEC:   top <= 3'(top - 3'h1);
        K_INC:   top <= 3'(top + 3'h1);
        K_FREE:  tag_empty_o[ex_dst] <= 1'b1;
        default: ;
      endcase
      if (ex.pops != 2'h0)
      begin
        tag_empty_o[top] <= 1'b1;
        top              <= 3'(top + {1'b0, ex.pops});
      end
      if (ex.pops == 2'h2)
        tag_empty_o[fcd_phys(top, 3'h1)] <= 1'b1;
    end
  end

  // Stack top mirror lags the register file by one cycle to stay a flop.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cond_code_o    <= 4'h0;
      int_flags_o    <= 3'h0;
      int_flags_we_o <= 1'b0;
      done_o         <= 1'b0;
      bad_opcode_o   <= 1'b0;
      busy_o         <= 1'b0;
      stack_top_o    <= '0;
    end
    else
    begin
      if (commit && ex.kind == K_CMPCC)
        cond_code_o <= {cmp_flags[FLG_ZERO], cmp_flags[FLG_PARITY], 1'b0, cmp_flags[FLG_CARRY]};
      if (commit && ex.kind == K_CMPFL)
        int_flags_o <= cmp_flags;
      int_flags_we_o <= commit && (ex.kind == K_CMPFL);
      done_o         <= commit;
      bad_opcode_o   <= commit && (ex.kind == K_BAD);
      busy_o         <= (next_q_count != 3'h0) || start || ((state == ST_EXEC) && !commit);
      stack_top_o    <= regs[top];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_move_len;
    start && d_start.kind == K_MOVE |-> !commit [*4] ##1 commit;
  endproperty
  a_move_len: assert property (p_move_len) else $error("move did not take four clocks");
  property p_move_hold;
    commit && ex.kind == K_MOVE && !move_ok |=> regs[top] == $past(regs[top]);
  endproperty
  a_move_hold: assert property (p_move_hold) else $error("move wrote with condition false");
  property p_cmp_len;
    start && d_start.kind == K_CMPCC && d_start.cyc == CYC_CMP |-> ##4 commit;
  endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare length wrong");
  property p_pop_twice;
    commit && ex.pops == 2'h2 |=> top == 3'($past(top) + 3'h2) && tag_empty_o[$past(top)];
  endproperty
  a_pop_twice: assert property (p_pop_twice) else $error("double pop wrong");
  property p_ucmp_len;
    start && d_start.kind == K_CMPFL && d_start.cyc == CYC_UCMP |-> ##9 commit ##1 int_flags_we_o;
  endproperty
  a_ucmp_len: assert property (p_ucmp_len) else $error("unordered compare timing wrong");
  property p_cos_len;
    start && d_start.kind == K_COS |-> ##92 commit;
  endproperty
  a_cos_len: assert property (p_cos_len) else $error("cosine length wrong");
  property p_dec;
    commit && ex.kind == K_DEC |=> top == 3'($past(top) - 3'h1);
  endproperty
  a_dec: assert property (p_dec) else $error("pointer decrement wrong");
  property p_inc_len;
    start && d_start.kind == K_INC |-> ##2 commit ##1 top == 3'($past(top, 3) + 3'h1);
  endproperty
  a_inc_len: assert property (p_inc_len) else $error("pointer increment wrong");
  property p_div_len;
    start && d_start.kind == K_DIV && d_start.cyc == CYC_DIV |-> ##24 commit;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");
  property p_idiv_len;
    start && d_start.kind == K_DIV && d_start.cyc == CYC_IDIV |-> ##34 commit;
  endproperty
  a_idiv_len: assert property (p_idiv_len) else $error("integer divide length wrong");
  property p_free;
    commit && ex.kind == K_FREE |=> tag_empty_o[$past(ex_dst)];
  endproperty
  a_free: assert property (p_free) else $error("tag release failed");
  // Ready is still low at the first edge after reset, so that edge is skipped.
  property p_queue;
    !$past(reset_i) |-> instr_ready_o == (q_count != 3'h4);
  endproperty
  a_queue: assert property (p_queue) else $error("queue ready mismatch");

  c_move: cover property (commit && ex.kind == K_MOVE && move_ok);
  c_pop2: cover property (commit && ex.pops == 2'h2);
  c_full: cover property (q_count == 3'h4);
  c_div:  cover property (commit && ex.kind == K_DIV && ex.use_mem);

endmodule // fcd_exec_unit

//--- fcd_int_model.sv
module fcd_int_model
  import fcd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Integer flags
  input  wire logic               flags_we_i,
  input  wire logic [2:0]         flags_i,
  input  wire logic               set_i,
  input  wire logic [2:0]         set_flags_i,
  output logic      [2:0]         flags_o,
  // Arithmetic datapath
  input  wire logic [1:0]         op_i,
  input  wire logic [DATA_W-1:0]  a_i,
  input  wire logic [DATA_W-1:0]  b_i,
  output logic      [DATA_W-1:0]  result_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A difference keeps operand order visible; idle returns a pattern, not the last value.
  assign result_o = (op_i == AOP_DIV) ? a_i - b_i : ~a_i;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      flags_o <= 3'h0;
    else if (set_i)
      flags_o <= set_flags_i;
    else if (flags_we_i)
      flags_o <= flags_i;
  end
endmodule // fcd_int_model

//--- fcd_exec_unit_test.sv
module fcd_exec_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fcd_pkg::*;
  localparam logic [79:0] ONE  = 80'h3FFF_8000_0000_0000_0000;
  localparam logic [79:0] TWO  = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] HALF = 80'h3FFE_8000_0000_0000_0000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic valid = 1'b0;
  logic [7:0] opc = 8'h00;
  logic [7:0] modrm = 8'h00;
  logic [79:0] operand = '0;
  logic ld = 1'b0;
  logic [2:0] ld_idx = 3'h0;
  logic [79:0] ld_data = '0;
  logic fset = 1'b0;
  logic [2:0] flags_in;
  logic [2:0] flags_out;
  logic [2:0] top;
  logic [1:0] aop;
  logic [1:0] aop_seen;
  logic [79:0] a, b, res, stop;
  logic [3:0] cc;
  logic [7:0] tags;
  logic ready, flags_we, busy, done, bad, we_seen, bad_seen;
  int n_errors = 0;
  int n_compared = 0;

  initial forever #12.5 clk = ~clk;

  fcd_exec_unit i_fcd_exec_unit (.clk_i(clk), .reset_i(reset), .instr_valid_i(valid), .instr_opcode_i(opc),
    .instr_modrm_i(modrm), .instr_operand_i(operand), .instr_ready_o(ready), .int_flags_i(flags_in),
    .int_flags_o(flags_out), .int_flags_we_o(flags_we), .arith_op_o(aop), .arith_a_o(a), .arith_b_o(b),
    .arith_result_i(res), .reg_load_i(ld), .reg_load_index_i(ld_idx), .reg_load_data_i(ld_data),
    .cond_code_o(cc), .top_pointer_o(top), .tag_empty_o(tags), .stack_top_o(stop), .busy_o(busy),
    .done_o(done), .bad_opcode_o(bad));

  fcd_int_model i_fcd_int_model (.clk_i(clk), .reset_i(reset), .flags_we_i(flags_we), .flags_i(flags_out),
    .set_i(fset), .set_flags_i(3'h0), .flags_o(flags_in), .op_i(aop), .a_i(a), .b_i(b), .result_o(res));

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Push one instruction at a falling edge and time its completion pulse.
  task automatic run(input logic [7:0] op, input logic [7:0] md, input logic [79:0] opd, input int cyc);
    int k;
    k = 1;
    aop_seen = 2'h0;
    while (ready !== 1'b1)
      @(negedge clk);
    opc = op;
    modrm = md;
    operand = opd;
    valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    valid = 1'b0;
    while (done !== 1'b1 && k < 200)
    begin
      aop_seen |= aop;
      @(negedge clk);
      k++;
    end
    we_seen = flags_we;
    bad_seen = bad;
    check("latency", k, cyc + 2);
    @(negedge clk);
  endtask

  task automatic load(input logic [2:0] idx, input logic [79:0] d);
    ld = 1'b1;
    ld_idx = idx;
    ld_data = d;
    @(negedge clk);
    ld = 1'b0;
  endtask

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("tags", tags, 8'hFF);
    check("ready", ready, 1'b1);
    load(3'h0, ONE);
    load(3'h1, TWO);
    @(negedge clk);
    check("tags", tags, 8'hFC);
    run(8'hD8, 8'hD1, '0, 4);
    check("cc", cc, 4'h1);
    run(8'hD8, 8'hD0, '0, 4);
    check("cc", cc, 4'h8);
    run(8'hDC, 8'h10, HALF, 4);
    check("cc", cc, 4'h0);
    run(8'hD8, 8'hF1, '0, 24);
    check("aop", aop_seen, AOP_DIV);
    check("top", stop, 80'hFFFF_0000_0000_0000_0000);
    run(8'hDB, 8'hF1, '0, 4);
    check("flags", flags_out, 3'h1);
    check("we", we_seen, 1'b1);
    run(8'hDB, 8'hC1, '0, 4);
    check("top", stop, 80'hFFFF_0000_0000_0000_0000);
    run(8'hDA, 8'hD9, '0, 4);
    check("top", stop, 80'hFFFF_0000_0000_0000_0000);
    fset = 1'b1;
    @(negedge clk);
    fset = 1'b0;
    run(8'hDB, 8'hC1, '0, 4);
    check("top", stop, TWO);
    run(8'hD9, 8'hF7, '0, 2);
    check("ptr", top, 3'h1);
    run(8'hD9, 8'hF6, '0, 4);
    check("ptr", top, 3'h0);
    run(8'hD8, 8'hD9, '0, 4);
    check("cc", cc, 4'h8);
    check("ptr", top, 3'h1);
    check("tags", tags, 8'hFD);
    run(8'hD9, 8'hFF, '0, 92);
    check("cos", stop, ~TWO);
    run(8'hDD, 8'hC0, '0, 4);
    check("tags", tags, 8'hFF);
    run(8'hDB, 8'hE8, '0, 9);
    check("flags", flags_out, 3'h4);
    check("we", we_seen, 1'b1);
    run(8'hDB, 8'hCF, '0, 4);
    check("top", stop, ~TWO);
    run(8'hDB, 8'hD7, '0, 4);
    check("top", stop, ~TWO);
    run(8'hDB, 8'hDF, '0, 4);
    check("top", stop, TWO);
    run(8'hDE, 8'h10, ONE, 9);
    check("cc", cc, 4'h0);
    run(8'hDA, 8'h30, ONE, 34);
    check("top", stop, 80'h0001_0000_0000_0000_0000);
    run(8'hD8, 8'h38, ONE, 24);
    check("top", stop, HALF);
    run(8'hDE, 8'hF9, '0, 24);
    check("top", stop, 80'hC001_8000_0000_0000_0000);
    check("ptr", top, 3'h2);
    run(8'hDE, 8'hD9, '0, 4);
    check("cc", cc, 4'h1);
    check("ptr", top, 3'h4);
    check("tags", tags, 8'hFF);
    load(3'h5, ONE);
    run(8'hDE, 8'hF1, '0, 24);
    check("top", stop, 80'hC000_8000_0000_0000_0000);
    run(8'hD9, 8'h00, '0, 1);
    check("bad", bad_seen, 1'b1);
    // One instruction runs while four more wait in the queue.
    opc = 8'hD9;
    modrm = 8'hFF;
    valid = 1'b1;
    repeat (4)
    begin
      @(negedge clk);
      check("ready", ready, 1'b1);
      modrm = 8'hF7;
    end
    @(negedge clk);
    valid = 1'b0;
    check("ready", ready, 1'b0);
    check("busy", busy, 1'b1);
    repeat (200) @(negedge clk);
    check("ptr", top, 3'h1);
    check("busy", busy, 1'b0);
    stop_test;
  end
endmodule // fcd_exec_unit_test
